// ### core/clk_sel_pkg.sv
package clk_sel_pkg;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SRC_INTERNAL, SRC_WORD, SRC_OPTICAL, SRC_AES, SRC_MADI
	} source_type;
	typedef enum logic [1:0] {IN_NO_SIGNAL, IN_LOCKED, IN_SYNCED}
		input_state_type;
	typedef enum logic [1:0] {SPEED_SINGLE, SPEED_DOUBLE, SPEED_QUAD}
		speed_type;
	// Per input view: lock flag, reported state and period in cycles
	typedef struct packed {
		logic lock;
		input_state_type state;
		logic [13:0] period;
	} input_status_type;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int NUM_IN = 4;
	localparam int CLK_PERIOD_NS = 4;
	localparam int LOSS_NS = 62500;
	localparam int LOSS_CYCLES = LOSS_NS / CLK_PERIOD_NS;
	localparam int MIN_PERIOD_NS = 5000;
	localparam logic [13:0] MIN_PERIOD_CYC =
		14'((MIN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int DOUBLE_EDGE_NS = 14286;
	localparam logic [13:0] DOUBLE_EDGE_CYC =
		14'(DOUBLE_EDGE_NS / CLK_PERIOD_NS);
	localparam int QUAD_EDGE_NS = 7143;
	localparam logic [13:0] QUAD_EDGE_CYC =
		14'(QUAD_EDGE_NS / CLK_PERIOD_NS);
	localparam int TOL_NS = 200;
	localparam logic [13:0] TOL_CYC = 14'(TOL_NS / CLK_PERIOD_NS);

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SOURCE = 8'h04;
	localparam logic [7:0] OFS_SYNC = 8'h08;
	localparam logic [7:0] OFS_PERIOD0 = 8'h0c;
	localparam logic [7:0] OFS_PERIOD3 = 8'h18;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
	localparam logic [7:0] OFS_IRQ_EN = 8'h20;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h24;
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_PREF_LSB = 1;
	localparam int CTRL_RATE_LSB = 4;
	localparam logic [6:0] CTRL_RESET = 7'h20;
	localparam int IRQ_SRC_CHANGE = 0;
	localparam int IRQ_LOCK_LOST = 1;

	// ----------------------------------------------------------------
	// Rates and channel counts
	// ----------------------------------------------------------------
	localparam logic [2:0] RATE_88K2 = 3'h3;
	localparam logic [2:0] RATE_176K4 = 3'h5;
	localparam logic [3:0] OPT_CH_SINGLE = 4'h8;
	localparam logic [3:0] OPT_CH_DOUBLE = 4'h4;
	localparam logic [3:0] OPT_CH_QUAD = 4'h2;
	localparam logic [6:0] MADI_CH_SINGLE = 7'h40;
	localparam logic [6:0] MADI_CH_DOUBLE = 7'h20;
	localparam logic [6:0] MADI_CH_QUAD = 7'h10;

endpackage : clk_sel_pkg

// ### core/audio_clock_source_select.sv
`timescale 1ns/100ps
// Summary of operation
// - Auto mode keeps watching every input for validity
// - Valid input replaces oscillator and becomes source
// - Lost reference moves to another valid input, else internal master clock
// - In auto mode the preferred input wins whenever it is valid
// - Otherwise scan other inputs in turn
// - No valid input anywhere selects internal mode
// - Each input reports none, locked or synced
// - Unmeasurable rate reads as no lock
// - Classify double and quad speed, drop channels
// - Spread samples over two or four slots
// - Optical port carries 8, 4 or 2 channels
// - MADI carries 64, 32 or 16 channels
// - Slave rate overrides host rate request
module audio_clock_source_select #(
	parameter logic [13:0] LOSS_CYCLES = 14'(clk_sel_pkg::LOSS_CYCLES)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] ref_clk_in,
	output clk_sel_pkg::source_type source_q,
	output logic master_q,
	output clk_sel_pkg::speed_type speed_q,
	output logic [2:0] internal_rate_q,
	output logic [2:0] slots_per_channel_q,
	output logic [3:0] optical_channels_q,
	output logic [6:0] madi_channels_q,
	output logic irq_q
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic near(input logic [13:0] a, b);
		logic [13:0] d;
		d = (a > b) ? a - b : b - a;
		return d <= clk_sel_pkg::TOL_CYC;
	endfunction : near

	function automatic clk_sel_pkg::speed_type period_speed(
		input logic [13:0] p);
		if (p < clk_sel_pkg::QUAD_EDGE_CYC)
			return clk_sel_pkg::SPEED_QUAD;
		else if (p < clk_sel_pkg::DOUBLE_EDGE_CYC)
			return clk_sel_pkg::SPEED_DOUBLE;
		return clk_sel_pkg::SPEED_SINGLE;
	endfunction : period_speed

	function automatic clk_sel_pkg::speed_type rate_speed(
		input logic [2:0] r);
		if (r >= clk_sel_pkg::RATE_176K4)
			return clk_sel_pkg::SPEED_QUAD;
		else if (r >= clk_sel_pkg::RATE_88K2)
			return clk_sel_pkg::SPEED_DOUBLE;
		return clk_sel_pkg::SPEED_SINGLE;
	endfunction : rate_speed

	// ----------------------------------------------------------------
	// Input synchronisers and edge detection
	// ----------------------------------------------------------------
	logic [3:0] meta_q, sync_q, hist_q, rise;
	// Two flops before anything looks at the reference pins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= 4'h0;
			sync_q <= 4'h0;
			hist_q <= 4'h0;
		end else begin
			meta_q <= ref_clk_in;
			sync_q <= meta_q;
			hist_q <= sync_q;
		end
	end
	assign rise = sync_q & ~hist_q;

	// ----------------------------------------------------------------
	// Period measurement and lock detection
	// ----------------------------------------------------------------
	logic [13:0] cnt_q [4];
	logic [13:0] period_q [4];
	logic [3:0] lock_q, lock_prev_q, lost;
	// Lock needs two matching periods inside the legal band, so one
	// glitch edge cannot make an input look valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 4; i++) begin
				cnt_q[i] <= 14'h0;
				period_q[i] <= 14'h0;
			end
			lock_q <= 4'h0;
			lock_prev_q <= 4'h0;
		end else begin
			lock_prev_q <= lock_q;
			for (int i = 0; i < 4; i++) begin
				if (rise[i]) begin
					cnt_q[i] <= 14'h1;
					period_q[i] <= cnt_q[i];
					lock_q[i] <= cnt_q[i] >= clk_sel_pkg::MIN_PERIOD_CYC &&
						near(cnt_q[i], period_q[i]);
				end else if (cnt_q[i] >= LOSS_CYCLES) begin
					period_q[i] <= 14'h0;
					lock_q[i] <= 1'b0;
				end else begin
					cnt_q[i] <= cnt_q[i] + 14'h1;
				end
			end
		end
	end
	assign lost = lock_prev_q & ~lock_q;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	logic [6:0] ctrl_q;
	logic mode_internal;
	logic [1:0] pref_idx;
	logic [2:0] rate_cfg;
	assign mode_internal = ctrl_q[clk_sel_pkg::CTRL_MODE_BIT];
	assign pref_idx = ctrl_q[clk_sel_pkg::CTRL_PREF_LSB +: 2];
	assign rate_cfg = ctrl_q[clk_sel_pkg::CTRL_RATE_LSB +: 3];

	// ----------------------------------------------------------------
	// Source selection
	// ----------------------------------------------------------------
	logic [1:0] cur_idx, scan_q;
	logic cur_ok, pref_ok, any_lock;
	clk_sel_pkg::source_type src_d, pref_src, scan_src;
	assign cur_idx = 2'(source_q - 3'h1);
	assign cur_ok = source_q != clk_sel_pkg::SRC_INTERNAL &&
		lock_q[cur_idx];
	assign pref_ok = lock_q[pref_idx];
	assign any_lock = |lock_q;
	assign pref_src = clk_sel_pkg::source_type'({1'b0, pref_idx} + 3'h1);
	assign scan_src = clk_sel_pkg::source_type'({1'b0, scan_q} + 3'h1);
	// Priority: forced internal, preferred, keep current, scan, fallback
	assign src_d = mode_internal ? clk_sel_pkg::SRC_INTERNAL :
		pref_ok ? pref_src :
		cur_ok ? source_q :
		lock_q[scan_q] ? scan_src :
		!any_lock ? clk_sel_pkg::SRC_INTERNAL :
		source_q;

	// ----------------------------------------------------------------
	// Per input status
	// ----------------------------------------------------------------
	clk_sel_pkg::input_status_type in_stat [4];
	logic [13:0] sel_period;
	assign sel_period = period_q[cur_idx];
	// Synced means same rate as the reference we run on
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			in_stat[i].lock = lock_q[i];
			in_stat[i].period = lock_q[i] ? period_q[i] : 14'h0;
			if (!lock_q[i])
				in_stat[i].state = clk_sel_pkg::IN_NO_SIGNAL;
			else if (!master_q && (2'(i) == cur_idx ||
				near(period_q[i], sel_period)))
				in_stat[i].state = clk_sel_pkg::IN_SYNCED;
			else
				in_stat[i].state = clk_sel_pkg::IN_LOCKED;
		end
	end

	// ----------------------------------------------------------------
	// Speed range and channel counts
	// ----------------------------------------------------------------
	clk_sel_pkg::speed_type speed_d;
	// External rate rules while slaved; host rate only when master
	assign speed_d = (src_d == clk_sel_pkg::SRC_INTERNAL) ?
		rate_speed(rate_cfg) :
		period_speed(period_q[2'(src_d - 3'h1)]);

	// Selection, scan pointer and the rate-derived outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			source_q <= clk_sel_pkg::SRC_INTERNAL;
			master_q <= 1'b1;
			scan_q <= 2'h0;
			speed_q <= clk_sel_pkg::SPEED_SINGLE;
			internal_rate_q <=
				clk_sel_pkg::CTRL_RESET[clk_sel_pkg::CTRL_RATE_LSB +: 3];
		end else begin
			source_q <= src_d;
			master_q <= src_d == clk_sel_pkg::SRC_INTERNAL;
			scan_q <= scan_q + 2'h1;
			speed_q <= speed_d;
			internal_rate_q <= rate_cfg;
		end
	end

	// Channels that the speed range cannot carry disappear
	always_comb begin
		case (speed_q)
			clk_sel_pkg::SPEED_QUAD: begin
				optical_channels_q = clk_sel_pkg::OPT_CH_QUAD;
				madi_channels_q = clk_sel_pkg::MADI_CH_QUAD;
				slots_per_channel_q = 3'h4;
			end
			clk_sel_pkg::SPEED_DOUBLE: begin
				optical_channels_q = clk_sel_pkg::OPT_CH_DOUBLE;
				madi_channels_q = clk_sel_pkg::MADI_CH_DOUBLE;
				slots_per_channel_q = 3'h2;
			end
			default: begin
				optical_channels_q = clk_sel_pkg::OPT_CH_SINGLE;
				madi_channels_q = clk_sel_pkg::MADI_CH_SINGLE;
				slots_per_channel_q = 3'h1;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// APB slave and interrupts
	// ----------------------------------------------------------------
	logic setup, wr, hit, clr_wr;
	logic [1:0] stat_q, en_q, ev, stat_d, en_d;
	logic [31:0] rd_d;
	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign clr_wr = wr && paddr == clk_sel_pkg::OFS_IRQ_CLR;
	assign hit = paddr <= clk_sel_pkg::OFS_IRQ_CLR && paddr[1:0] == 2'h0;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign ev = {|lost, src_d != source_q};
	// Next status and enable; the irq level is built from both
	assign stat_d = (stat_q & ~(clr_wr ? pwdata[1:0] : 2'h0)) | ev;
	assign en_d = (wr && paddr == clk_sel_pkg::OFS_IRQ_EN) ?
		pwdata[1:0] : en_q;
	// Read mux; write-only clear reads as zero
	assign rd_d = paddr == clk_sel_pkg::OFS_CTRL ? {25'h0, ctrl_q} :
		paddr == clk_sel_pkg::OFS_SOURCE ? {15'h0, madi_channels_q,
			optical_channels_q, speed_q, master_q, source_q} :
		paddr == clk_sel_pkg::OFS_SYNC ? {24'h0, in_stat[3].state,
			in_stat[2].state, in_stat[1].state, in_stat[0].state} :
		(paddr >= clk_sel_pkg::OFS_PERIOD0 &&
			paddr <= clk_sel_pkg::OFS_PERIOD3) ?
			{18'h0, in_stat[2'(paddr[7:2] - 6'h3)].period} :
		paddr == clk_sel_pkg::OFS_IRQ_STAT ? {30'h0, stat_q} :
		paddr == clk_sel_pkg::OFS_IRQ_EN ? {30'h0, en_q} : 32'h0;

	// Sticky status: a new event beats a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= clk_sel_pkg::CTRL_RESET;
			en_q <= 2'h0;
			stat_q <= 2'h0;
			irq_q <= 1'b0;
			prdata <= 32'h0;
		end else begin
			if (wr && paddr == clk_sel_pkg::OFS_CTRL)
				ctrl_q <= pwdata[6:0];
			en_q <= en_d;
			stat_q <= stat_d;
			irq_q <= |(stat_d & en_d); // Follows a new enable at once
			if (setup)
				prdata <= rd_d;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence auto_pref_valid;
		!mode_internal && pref_ok;
	endsequence
	sequence stuck_unlocked;
		!mode_internal && !pref_ok && !cur_ok && any_lock;
	endsequence

	forced_internal_a: assert property (
		mode_internal |=> source_q == clk_sel_pkg::SRC_INTERNAL && master_q)
		else $error("internal mode not honoured");
	pref_wins_a: assert property (
		auto_pref_valid |=> source_q == $past(pref_src))
		else $error("preferred input not chosen");
	scan_finds_a: assert property (
		stuck_unlocked |-> ##[1:5]
		(cur_ok || !any_lock || mode_internal))
		else $error("scan did not find a locked input");
	fallback_a: assert property (
		!any_lock |=> master_q && source_q == clk_sel_pkg::SRC_INTERNAL)
		else $error("no fallback to internal clock");
	no_lock_read_a: assert property (
		setup && paddr == clk_sel_pkg::OFS_PERIOD0 && !lock_q[0]
		|=> prdata == 32'h0)
		else $error("unlocked input shows a rate");
	selected_sync_a: assert property (
		!master_q && lock_q[cur_idx] |->
		in_stat[cur_idx].state == clk_sel_pkg::IN_SYNCED)
		else $error("selected input not synced");
	master_rate_a: assert property (
		master_q ##1 master_q |-> speed_q == rate_speed($past(rate_cfg)))
		else $error("master speed not from host rate");
	quad_counts_a: assert property (
		speed_q == clk_sel_pkg::SPEED_QUAD |->
		optical_channels_q == 4'h2 && madi_channels_q == 7'h10)
		else $error("quad speed channel count wrong");
	src_event_a: assert property (
		$changed(source_q) |-> stat_q[clk_sel_pkg::IRQ_SRC_CHANGE] &&
		(!en_q[0] || irq_q))
		else $error("source change not flagged");

endmodule : audio_clock_source_select

// ### tb/ref_clock_gen.sv
`timescale 1ns/100ps
// ----------------------------------------
// Outside gear supplying one clock reference
// ----------------------------------------
module ref_clock_gen (
	input wire logic run,
	input wire logic [15:0] half_tenth_ns,
	output logic ref_clk
);
	// Toggles only while enabled; idles low so no stray edge leaks out
	initial begin
		ref_clk = 1'b0;
		forever begin
			if (run === 1'b1) begin
				#(half_tenth_ns * 0.1) ref_clk = ~ref_clk;
			end else begin
				ref_clk = 1'b0;
				@(run);
			end
		end
	end
endmodule : ref_clock_gen

// ### tb/tb_audio_clock_source_select.sv
`timescale 1ns/100ps
module tb_audio_clock_source_select;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic master_q, irq_q;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	wire [3:0] ref_clk_in;
	logic [3:0] run;
	logic [3:0][15:0] half;
	logic [2:0] internal_rate_q, slots_per_channel_q;
	logic [3:0] optical_channels_q;
	logic [6:0] madi_channels_q;
	clk_sel_pkg::source_type source_q;
	clk_sel_pkg::speed_type speed_q;
	int err_total, checked;

	// Short loss timeout keeps the run brief; must exceed slowest period
	audio_clock_source_select #(.LOSS_CYCLES(14'h1f40)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ref_clk_in(ref_clk_in),
		.source_q(source_q), .master_q(master_q), .speed_q(speed_q),
		.internal_rate_q(internal_rate_q),
		.slots_per_channel_q(slots_per_channel_q),
		.optical_channels_q(optical_channels_q),
		.madi_channels_q(madi_channels_q), .irq_q(irq_q)
	);

	// One outside source per reference pin
	for (genvar i = 0; i < 4; i++) begin : ref_g
		ref_clock_gen ref_u (.run(run[i]), .half_tenth_ns(half[i]),
			.ref_clk(ref_clk_in[i]));
	end

	// Clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : chk

	// Extra idle edge at the end avoids a double drive of psel
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 64) chk("pready", 32'h0, 32'h1);
		@(posedge pclk);
	endtask : apb

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp,
		input string name);
		apb(1'b0, a, 32'h0);
		chk(name, rd, exp);
	endtask : rdchk

	task automatic wait_src(input clk_sel_pkg::source_type s);
		int n;
		n = 0;
		while (source_q !== s && n < 40000) begin
			@(posedge pclk);
			n++;
		end
		repeat (2) @(posedge pclk);
		chk("source", 32'(source_q), 32'(s));
	endtask : wait_src

	task automatic results;
		if (err_total == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : results

	// Watchdog well beyond the longest lock and loss sequence
	initial begin
		#300000;
		err_total++;
		results();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		run = 4'h0;
		half = {4{16'h6590}};
		err_total = 0;
		checked = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdchk(clk_sel_pkg::OFS_CTRL, 32'h20, "ctrl reset");
		chk("mapped err", 32'(er), 32'h0);
		rdchk(clk_sel_pkg::OFS_SOURCE, 32'h00010208, "source reset");
		chk("slots reset", 32'(slots_per_channel_q), 32'h1);
		apb(1'b0, 8'h28, 32'h0);
		chk("unmapped err", 32'(er), 32'h1);
		chk("unmapped data", rd, 32'h0);
		apb(1'b1, 8'h02, 32'hffffffff);
		chk("misaligned err", 32'(er), 32'h1);
		rdchk(clk_sel_pkg::OFS_CTRL, 32'h20, "ctrl kept");
		// Too fast a reference never locks
		half[0] <= 16'h0271;
		run[0] <= 1'b1;
		repeat (3000) @(posedge pclk);
		rdchk(clk_sel_pkg::OFS_PERIOD0, 32'h0, "word period");
		rdchk(clk_sel_pkg::OFS_SYNC, 32'h0, "sync none");
		chk("still internal", 32'(source_q), 32'h0);
		run[0] <= 1'b0;
		apb(1'b1, clk_sel_pkg::OFS_IRQ_EN, 32'h3);
		// Quad speed reference on AES
		half[2] <= 16'h6590;
		run[2] <= 1'b1;
		wait_src(clk_sel_pkg::SRC_AES);
		chk("slaved", 32'(master_q), 32'h0);
		rdchk(clk_sel_pkg::OFS_SOURCE, 32'h000040a3, "quad");
		chk("quad slots", 32'(slots_per_channel_q), 32'h4);
		chk("quad optical", 32'(optical_channels_q), 32'h2);
		chk("quad madi", 32'(madi_channels_q), 32'h10);
		chk("irq set", 32'(irq_q), 32'h1);
		rdchk(clk_sel_pkg::OFS_IRQ_STAT, 32'h1, "irq stat");
		apb(1'b1, clk_sel_pkg::OFS_IRQ_CLR, 32'h1);
		chk("irq cleared", 32'(irq_q), 32'h0);
		// Preferred MADI at double speed takes over from AES
		apb(1'b1, clk_sel_pkg::OFS_CTRL, 32'h26);
		half[3] <= 16'hcb20;
		run[3] <= 1'b1;
		wait_src(clk_sel_pkg::SRC_MADI);
		rdchk(clk_sel_pkg::OFS_SOURCE, 32'h00008114, "double");
		chk("double slots", 32'(slots_per_channel_q), 32'h2);
		rdchk(clk_sel_pkg::OFS_SYNC, 32'h90, "sync mixed");
		apb(1'b1, clk_sel_pkg::OFS_CTRL, 32'h66);
		chk("slave speed", 32'(speed_q), 32'h1);
		// Rate output lags the control write by one edge
		@(posedge pclk);
		chk("rate kept", 32'(internal_rate_q), 32'h6);
		// Loss of MADI falls back to AES, then to internal
		run[3] <= 1'b0;
		wait_src(clk_sel_pkg::SRC_AES);
		rdchk(clk_sel_pkg::OFS_IRQ_STAT, 32'h3, "irq lost");
		chk("irq on", 32'(irq_q), 32'h1);
		apb(1'b1, clk_sel_pkg::OFS_IRQ_EN, 32'h0);
		chk("irq masked", 32'(irq_q), 32'h0);
		// Forced internal mode overrides a locked input, then releases it
		apb(1'b1, clk_sel_pkg::OFS_CTRL, 32'h67);
		wait_src(clk_sel_pkg::SRC_INTERNAL);
		chk("forced master", 32'(master_q), 32'h1);
		apb(1'b1, clk_sel_pkg::OFS_CTRL, 32'h66);
		wait_src(clk_sel_pkg::SRC_AES);
		run[2] <= 1'b0;
		wait_src(clk_sel_pkg::SRC_INTERNAL);
		chk("master again", 32'(master_q), 32'h1);
		rdchk(clk_sel_pkg::OFS_SOURCE, 32'h000040a8, "fallback");
		chk("fallback rate", 32'(internal_rate_q), 32'h6);
		results();
	end
endmodule : tb_audio_clock_source_select
